// ---- bench/sspl_link_props.sv ----
// Checker for the select, clock, data and strobe lines of the loader link.
`timescale 1ns/1ps
`default_nettype none
module sspl_link_props
    import sspl_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [2:0] module_select_lines,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic latch_strobe,
    input wire logic lock_detect
);
    logic clk_q;
    logic [5:0] bits;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    // Counts clock pulses of the current word so the strobe can be tied to a full word.
    always_ff @(posedge CLOCK)
    begin
        clk_q <= ser_clk;
        if (RST || module_select_lines == 3'h0)
            bits <= 6'h00;
        else if (ser_clk && !clk_q)
            bits <= bits + 6'h01;
    end
    sel_clk_a: assert property ($rose(ser_clk) |-> module_select_lines != 3'h0)
        else $error("clock pulse without select");
    sel_hold_a: assert property ($rose(ser_clk) |-> $stable(module_select_lines))
        else $error("select moved at clock edge");
    clk_high_a: assert property ($rose(ser_clk) |-> ser_clk [*5] ##1 !ser_clk)
        else $error("clock high phase wrong");
    clk_low_a: assert property ($fell(ser_clk) |-> !ser_clk [*5])
        else $error("clock low phase short");
    data_hold_a: assert property (ser_clk |-> $stable(ser_data))
        else $error("data moved while clock high");
    word_len_a: assert property ($rose(latch_strobe) |-> bits == 6'h20)
        else $error("strobe not after 32 bits");
    strobe_len_a: assert property ($rose(latch_strobe) |-> latch_strobe [*5] ##1 !latch_strobe)
        else $error("strobe length wrong");
    strobe_idle_a: assert property (latch_strobe |-> !ser_clk && module_select_lines != 3'h0)
        else $error("strobe with clock or no select");
    lock_seen_c: cover property ($rose(lock_detect));
endmodule // sspl_link_props
`default_nettype wire

// ---- bench/test_synth_serial_program_loader.sv ----
// Bench joining the loader controller and device, checked against a small model.
`timescale 1ns/1ps
`default_nettype none
module test_synth_serial_program_loader
    import sspl_pkg::*;
();
    logic clk, rst, cyc, stb, we, locked, ck_q, ack, irq, lamp, ld_p, cb;
    logic [4:0] adr;
    logic [2:0] sel;
    logic [31:0] dat, rd, cap, dat_o;
    logic [13:0] rdv, r, m_ref;
    logic [9:0] mdv, m, m_main;
    logic [6:0] sdv, s, m_swal;
    int errors, samples_checked, loads, mloads;
    sspl_link_if i_sspl_link_if ();
    sspl_controller i_sspl_controller (.CLOCK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .IRQ(irq), .LINK(i_sspl_link_if.controller));
    sspl_device i_sspl_device (.CLOCK(clk), .RST(rst), .LINK(i_sspl_link_if.device),
        .LOOP_LOCKED(locked), .FAULT_LAMP(lamp), .REF_DIV(rdv), .MAIN_DIV(mdv),
        .SWAL_DIV(sdv), .LOAD_PULSE(ld_p));
    sspl_link_props i_sspl_link_props (.CLOCK(clk), .RST(rst),
        .module_select_lines(i_sspl_link_if.module_select_lines),
        .ser_clk(i_sspl_link_if.ser_clk), .ser_data(i_sspl_link_if.ser_data),
        .latch_strobe(i_sspl_link_if.latch_strobe), .lock_detect(i_sspl_link_if.lock_detect));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Records each word as it crosses the wire, and counts latch updates.
    always @(posedge clk)
    begin
        ck_q <= i_sspl_link_if.ser_clk;
        if (i_sspl_link_if.ser_clk && !ck_q)
            cap <= {cap[30:0], i_sspl_link_if.ser_data};
        if (ld_p === 1'b1)
            loads++;
    end
    task report_and_stop;
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task hang;
        errors++;
        report_and_stop;
    endtask
    task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
            hang;
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task lock_to(input logic l);
        locked <= l;
        repeat (6) @(posedge clk);
        chk(32'({i_sspl_link_if.lock_detect, lamp}), 32'({l, !l}));
        wb(1'b0, {1'b0, SSPL_OFS_CTRL}, 32'h0);
        chk(32'(rd[5]), 32'(l));
        wb(1'b0, SSPL_REG_STAT, 32'h0);
        chk(32'(rd[2:1]), l ? 32'h2 : 32'h3);
    endtask
    initial
    begin
        {rst, cyc, stb, we, locked, ck_q} = 6'h21;
        {adr, dat, cap, m_ref, m_main, m_swal} = '0;
        {errors, samples_checked, loads, mloads} = '0;
        void'($urandom(32'hB06BB811));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++)
        begin
            r = 14'($urandom);
            m = 10'($urandom);
            s = 7'($urandom);
            sel = (i == 4) ? 3'h5 : SSPL_ADDR;
            cb = (i != 2);
            wb(1'b1, {1'b0, SSPL_OFS_REF}, 32'(r));
            wb(1'b1, {1'b0, SSPL_OFS_MAIN}, 32'(m));
            wb(1'b1, {1'b0, SSPL_OFS_SWAL}, 32'(s));
            wb(1'b1, {1'b0, SSPL_OFS_CTRL}, {27'h0, cb, sel, 1'b1});
            for (int n = 0; n < 200 && rd[SSPL_ST_DONE] !== 1'b1; n++)
                wb(1'b0, SSPL_REG_STAT, 32'h0);
            if (rd[SSPL_ST_DONE] !== 1'b1)
                hang;
            chk(cap, {r, m, s, cb});
            if (sel == SSPL_ADDR && cb)
            begin
                {m_ref, m_main, m_swal} = {r, m, s};
                mloads++;
            end
            repeat (10) @(posedge clk);
            chk(32'({rdv, mdv, sdv}), 32'({m_ref, m_main, m_swal}));
            chk(32'(irq), 32'(i > 0));
            wb(1'b1, SSPL_REG_STAT, 32'h7);
            @(posedge clk);
            chk(32'(irq), 32'h0);
            if (i == 0)
                wb(1'b1, SSPL_REG_MASK, 32'h1);
        end
        chk(32'(loads), 32'(mloads));
        lock_to(1'b1);
        lock_to(1'b0);
        report_and_stop;
    end
endmodule // test_synth_serial_program_loader
`default_nettype wire

// ---- rtl/sspl_controller.sv ----
// Controller end: Wishbone registers, serial word sender and word-done and lock-status interrupt.
`timescale 1ns/1ps
`default_nettype none
module sspl_controller
    import sspl_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic IRQ,
    sspl_link_if.controller LINK
);
    typedef struct packed {
        sspl_state_e st;
        logic [SSPL_REF_BITS-1:0] ref_v;
        logic [SSPL_MAIN_BITS-1:0] main_v;
        logic [SSPL_SWAL_BITS-1:0] swal_v;
        logic [2:0] sel;
        logic cbit;
        logic [2:0] stat;
        logic [2:0] mask;
        logic [SSPL_WORD_BITS-1:0] word;
        logic [5:0] cnt;
        logic [7:0] div;
        logic [1:0] lock_s;
        logic lock_prev;
        logic ack;
        logic [31:0] dat;
        logic sclk;
        logic sdat;
        logic stb;
    } sspl_ctl_s;

    sspl_ctl_s r;
    sspl_ctl_s next_r;
    logic wr;
    logic rd;
    logic tick;
    logic [2:0] ev;

    // Register decode shared by every write of the bus; reads decode the address in their own case.
    function automatic logic reg_hit(input logic [4:0] adr, input logic [4:0] ofs);
        reg_hit = (adr == ofs);
    endfunction

    always_comb
    begin
        next_r = r;
        // Writes need the low byte lane, which also gates the upper bits of the 14-bit ref and 10-bit main fields.
        wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~r.ack & WB_SEL_I[0];
        rd = WB_CYC_I & WB_STB_I & ~r.ack;
        // Ack rises one cycle after the request and never twice in a row.
        next_r.ack = WB_CYC_I & WB_STB_I & ~r.ack;
        // The lock flag comes from the far end, so it passes two flops first.
        next_r.lock_s = {r.lock_s[0], LINK.lock_detect};
        next_r.lock_prev = r.lock_s[1];
        // The divider paces each half period of the serial clock.
        tick = (r.div == SSPL_HALF_DIV);
        next_r.div = tick ? 8'h00 : r.div + 8'h01;
        ev = 3'b000;
        ev[SSPL_ST_LOST] = r.lock_prev & ~r.lock_s[1];
        ev[SSPL_ST_GAIN] = ~r.lock_prev & r.lock_s[1];
        case (r.st)
            SSPL_IDLE:
            begin
                next_r.sclk = 1'b0;
                next_r.stb = 1'b0;
                // The word is frozen here so later register writes cannot tear it.
                if (wr && reg_hit(WB_ADR_I, {1'b0, SSPL_OFS_CTRL}) && WB_DAT_I[SSPL_CTRL_GO])
                begin
                    next_r.sel = WB_DAT_I[3:1];
                    next_r.word = {r.ref_v, r.main_v, r.swal_v, WB_DAT_I[SSPL_CTRL_CB]};
                    next_r.cnt = 6'(SSPL_WORD_BITS);
                    next_r.div = 8'h00;
                    next_r.st = SSPL_LOW;
                end
            end
            SSPL_LOW:
            begin
                next_r.sdat = r.word[SSPL_WORD_BITS-1];
                if (tick)
                begin
                    next_r.sclk = 1'b1;
                    next_r.st = SSPL_HIGH;
                end
            end
            SSPL_HIGH:
            begin
                if (tick)
                begin
                    next_r.sclk = 1'b0;
                    next_r.word = {r.word[SSPL_WORD_BITS-2:0], 1'b0};
                    next_r.cnt = r.cnt - 6'h01;
                    next_r.st = (r.cnt == 6'h01) ? SSPL_STROBE : SSPL_LOW;
                end
            end
            SSPL_STROBE:
            begin
                // The strobe rises only after the last falling clock edge.
                if (tick)
                begin
                    next_r.stb = ~r.stb;
                    next_r.st = r.stb ? SSPL_GAP : SSPL_STROBE;
                end
            end
            SSPL_GAP:
            begin
                // Select stays up through the strobe and drops a half period later.
                if (tick)
                begin
                    next_r.sel = 3'h0;
                    next_r.st = SSPL_IDLE;
                end
            end
            default: next_r.st = SSPL_IDLE;
        endcase
        // Word sent is flagged as the select lines drop.
        if (r.st == SSPL_GAP && tick)
        begin
            ev[SSPL_ST_DONE] = 1'b1;
        end
        if (wr && reg_hit(WB_ADR_I, {1'b0, SSPL_OFS_REF}))
        begin
            next_r.ref_v = WB_DAT_I[SSPL_REF_BITS-1:0];
        end
        if (wr && reg_hit(WB_ADR_I, {1'b0, SSPL_OFS_MAIN}))
        begin
            next_r.main_v = WB_DAT_I[SSPL_MAIN_BITS-1:0];
        end
        if (wr && reg_hit(WB_ADR_I, {1'b0, SSPL_OFS_SWAL}))
        begin
            next_r.swal_v = WB_DAT_I[SSPL_SWAL_BITS-1:0];
        end
        if (wr && reg_hit(WB_ADR_I, SSPL_REG_MASK))
        begin
            next_r.mask = WB_DAT_I[2:0];
        end
        // A new event wins over a clear in the same cycle.
        next_r.stat = r.stat;
        if (wr && reg_hit(WB_ADR_I, SSPL_REG_STAT))
        begin
            next_r.stat = r.stat & ~WB_DAT_I[2:0];
        end
        next_r.stat = next_r.stat | ev;
        // Unmapped addresses read as zero.
        next_r.dat = 32'h0000_0000;
        if (rd)
        begin
            case (WB_ADR_I)
                {1'b0, SSPL_OFS_REF}: next_r.dat = {18'h0, r.ref_v};
                {1'b0, SSPL_OFS_MAIN}: next_r.dat = {22'h0, r.main_v};
                {1'b0, SSPL_OFS_SWAL}: next_r.dat = {25'h0, r.swal_v};
                {1'b0, SSPL_OFS_CTRL}: next_r.dat = {26'h0, r.lock_s[1], 1'b0, r.sel,
                    r.st != SSPL_IDLE};
                SSPL_REG_STAT: next_r.dat = {29'h0, r.stat};
                SSPL_REG_MASK: next_r.dat = {29'h0, r.mask};
                default: next_r.dat = 32'h0000_0000;
            endcase
        end
    end

    // Reset clears every register, which idles the link with select 000.
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign WB_ACK_O = r.ack;
    assign WB_DAT_O = r.dat;
    // The interrupt is a level while any unmasked status bit is set.
    assign IRQ = |(r.stat & r.mask);
    assign LINK.module_select_lines = r.sel;
    assign LINK.ser_clk = r.sclk;
    assign LINK.ser_data = r.sdat;
    assign LINK.latch_strobe = r.stb;
endmodule // sspl_controller
`default_nettype wire

// ---- rtl/sspl_device.sv ----
// Synthesizer end: address gate, serial shift register, divider latches and lock reporting.
`timescale 1ns/1ps
`default_nettype none
module sspl_device
    import sspl_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    sspl_link_if.device LINK,
    input wire logic LOOP_LOCKED,
    output logic FAULT_LAMP,
    output logic [SSPL_REF_BITS-1:0] REF_DIV,
    output logic [SSPL_MAIN_BITS-1:0] MAIN_DIV,
    output logic [SSPL_SWAL_BITS-1:0] SWAL_DIV,
    output logic LOAD_PULSE
);
    typedef struct packed {
        logic [2:0] sel_a;
        logic [2:0] sel_b;
        logic [2:0] io_a;
        logic [2:0] io_b;
        logic clk_prev;
        logic stb_prev;
        logic [1:0] lock_s;
        logic [SSPL_WORD_BITS-1:0] shift;
        logic [SSPL_REF_BITS-1:0] ref_div;
        logic [SSPL_MAIN_BITS-1:0] main_div;
        logic [SSPL_SWAL_BITS-1:0] swal_div;
        logic load;
        logic lock_out;
    } sspl_dev_s;

    sspl_dev_s r;
    sspl_dev_s next_r;
    logic hit;
    logic gclk;
    logic gstb;

    always_comb
    begin
        next_r = r;
        next_r.sel_a = LINK.module_select_lines;
        next_r.sel_b = r.sel_a;
        next_r.io_a = {LINK.ser_clk, LINK.ser_data, LINK.latch_strobe};
        next_r.io_b = r.io_a;
        next_r.lock_s = {r.lock_s[0], LOOP_LOCKED};
        hit = (r.sel_b == SSPL_ADDR);
        gclk = hit & r.io_b[2];
        gstb = hit & r.io_b[0];
        next_r.clk_prev = gclk;
        next_r.stb_prev = gstb;
        next_r.load = 1'b0;
        if (gclk && !r.clk_prev)
        begin
            next_r.shift = {r.shift[SSPL_WORD_BITS-2:0], r.io_b[1]};
        end
        if (gstb && !r.stb_prev && r.shift[0])
        begin
            // Field layout follows arrival order, first bits highest.
            next_r.ref_div = r.shift[SSPL_WORD_BITS-1 -: SSPL_REF_BITS];
            next_r.main_div = r.shift[SSPL_SWAL_BITS+SSPL_MAIN_BITS -: SSPL_MAIN_BITS];
            next_r.swal_div = r.shift[SSPL_SWAL_BITS:1];
            next_r.load = 1'b1;
        end
        next_r.lock_out = r.lock_s[1];
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign LINK.lock_detect = r.lock_out;
    assign FAULT_LAMP = ~r.lock_out;
    assign REF_DIV = r.ref_div;
    assign MAIN_DIV = r.main_div;
    assign SWAL_DIV = r.swal_div;
    assign LOAD_PULSE = r.load;
endmodule // sspl_device
`default_nettype wire

// ---- rtl/sspl_link_if.sv ----
// Interface carrying the select, clock, data, strobe and lock lines between both ends.
`timescale 1ns/1ps
`default_nettype none
interface sspl_link_if;
    logic [2:0] module_select_lines;
    logic ser_clk;
    logic ser_data;
    logic latch_strobe;
    logic lock_detect;
    modport controller (output module_select_lines, ser_clk, ser_data, latch_strobe,
        input lock_detect);
    modport device (input module_select_lines, ser_clk, ser_data, latch_strobe,
        output lock_detect);
endinterface
`default_nettype wire

// ---- rtl/sspl_pkg.sv ----
// Package with the constants shared by both ends of the synthesizer loader link.
package sspl_pkg;
    localparam int SSPL_REF_BITS = 14;
    localparam int SSPL_MAIN_BITS = 10;
    localparam int SSPL_SWAL_BITS = 7;
    localparam int SSPL_WORD_BITS = SSPL_REF_BITS + SSPL_MAIN_BITS + SSPL_SWAL_BITS + 1;
    localparam logic [2:0] SSPL_ADDR = 3'h2;
    localparam logic [5:0] SSPL_CNT_W = 6'h06;
    // Controller register offsets on its Wishbone port.
    localparam logic [3:0] SSPL_OFS_REF = 4'h0;
    localparam logic [3:0] SSPL_OFS_MAIN = 4'h4;
    localparam logic [3:0] SSPL_OFS_SWAL = 4'h8;
    localparam logic [3:0] SSPL_OFS_CTRL = 4'hC;
    localparam logic [4:0] SSPL_REG_STAT = 5'h10;
    localparam logic [4:0] SSPL_REG_MASK = 5'h14;
    // Control register: bit 0 start, bits 3:1 select lines, bit 4 control bit value.
    localparam int SSPL_CTRL_GO = 0;
    localparam int SSPL_CTRL_CB = 4;
    // Status bits: 0 word done, 1 lock lost, 2 lock gained.
    localparam int SSPL_ST_DONE = 0;
    localparam int SSPL_ST_LOST = 1;
    localparam int SSPL_ST_GAIN = 2;
    localparam logic [7:0] SSPL_HALF_DIV = 8'h04;
    typedef enum logic [2:0] {
        SSPL_IDLE = 3'b000,
        SSPL_LOW = 3'b001,
        SSPL_HIGH = 3'b010,
        SSPL_STROBE = 3'b011,
        SSPL_GAP = 3'b100
    } sspl_state_e;
endpackage
